// File: design/fcl_pkg.sv
// Shared constants and types for the flash command launch control block.
package fcl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus and register map.
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_DIV = 8'h00;
   localparam logic [7:0] OFS_IDX = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_CCOB = 8'h10;
   localparam logic [7:0] OFS_VER = 8'h14;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
   localparam logic [7:0] OFS_PROT = 8'h20;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions and widths.
   localparam int DIV_W = 7;
   localparam int DIV_LOADED_BIT = 7;
   localparam int STAT_COMMAND_COMPLETE_FLAG_BIT = 7;
   localparam int STAT_ACCESS_ERROR_FLAG_BIT = 5;
   localparam int STAT_PVIOL_BIT = 4;
   localparam int STAT_MODE_BIT = 0;
   localparam int IDX_W = 3;
   localparam int SLOT_N = 6;
   localparam int WORD_W = 16;
   localparam int RESULT_SLOT = 2;
   localparam int CMD_MSB = 15;
   localparam int CMD_LSB = 8;
   localparam int ADDR_HI_W = 2;
   localparam int GADDR_W = 18;
   localparam int PROT_EN_BIT = 7;
   localparam int PROT_SIZE_W = 4;
   localparam int IRQ_W = 2;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_ACCESS_ERROR_FLAG_BIT = 1;
   localparam int VER_W = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values.
   localparam logic [DIV_W-1:0] DIV_RST = 7'h00;
   localparam logic [7:0] PROT_RST = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
   localparam logic [IDX_W-1:0] IDX_RST = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Information row version word and protected window.
   localparam logic [GADDR_W-1:0] INFO_ROW_VERSION_ADDR = 18'h0_40B6;
   localparam logic [VER_W-1:0] VER_NONE_LO = 4'h0;
   localparam logic [VER_W-1:0] VER_NONE_HI = 4'hF;
   localparam logic [GADDR_W-1:0] PROT_BASE = 18'h0_4400;
   localparam int PROT_GRANULE_SHIFT = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Command codes and their run lengths in timebase ticks.
   localparam logic [7:0] CMD_ERASE_VERIFY_ALL = 8'h01;
   localparam logic [7:0] CMD_PROGRAM = 8'h02;
   localparam logic [7:0] CMD_ERASE_ALL = 8'h03;
   localparam logic [WORD_W-1:0] VERIFY_TICKS = 16'h0010;
   localparam logic [WORD_W-1:0] PROGRAM_TICKS = 16'h0020;
   localparam logic [WORD_W-1:0] ERASE_TICKS = 16'h0040;

   ////////////////////////////////////////////////////////////////////////////
   // Clock figures.
   localparam int PCLK_HZ = 40_000_000;
   localparam int TIMEBASE_TARGET_HZ = 1_000_000;
   localparam int DIV_RECOMMENDED = PCLK_HZ / TIMEBASE_TARGET_HZ - 1;

   typedef enum logic [2:0] {
      FCL_IDLE = 3'b001,
      FCL_RUN = 3'b010,
      FCL_DONE = 3'b100
   } fcl_exec_state_type;

endpackage

// File: design/fcl_exec_if.sv
// Interface carrying launch requests and results between controller and executor.
`timescale 1ns/1ps
`default_nettype none
interface fcl_exec_if;
   import fcl_pkg::*;
   logic launch;
   logic [7:0] cmd_code;
   logic [GADDR_W-1:0] cmd_addr;
   logic div_loaded;
   logic special_mode;
   logic [7:0] prot;
   logic [DIV_W-1:0] divider_value_field;
   logic done;
   logic acc_err;
   logic prot_viol;
   logic result_we;
   logic [WORD_W-1:0] result;
   modport ctrl (output launch, cmd_code, cmd_addr, div_loaded, special_mode, prot, divider_value_field,
                 input done, acc_err, prot_viol, result_we, result);
   modport exec (input launch, cmd_code, cmd_addr, div_loaded, special_mode, prot, divider_value_field,
                 output done, acc_err, prot_viol, result_we, result);
endinterface
`default_nettype wire

// File: design/fcl_cmd_array.sv
// Indexed command object storage with result write-back.
`timescale 1ns/1ps
`default_nettype none
module fcl_cmd_array
   import fcl_pkg::*;
#(
   parameter int SLOTS = SLOT_N
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [IDX_W-1:0] wr_idx,
   input wire logic [WORD_W-1:0] wr_data,
   input wire logic [IDX_W-1:0] rd_idx,
   output logic [WORD_W-1:0] rd_data,
   input wire logic res_we,
   input wire logic [WORD_W-1:0] res_data,
   output logic [WORD_W-1:0] slot0,
   output logic [WORD_W-1:0] slot1
);
   logic [WORD_W-1:0] mem_q [SLOTS];

   // Indices at or above SLOTS match no entry, so writes there fall away.
   for (genvar i = 0; i < SLOTS; i++) begin : g_slot
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            mem_q[i] <= '0;
         end else if (res_we && i == RESULT_SLOT) begin
            mem_q[i] <= res_data;
         end else if (wr_en && wr_idx == IDX_W'(i)) begin
            mem_q[i] <= wr_data;
         end
      end
   end

   always_comb begin
      rd_data = '0;
      if (int'(rd_idx) < SLOTS) begin
         rd_data = mem_q[rd_idx];
      end
   end

   assign slot0 = mem_q[0];
   assign slot1 = mem_q[1];
endmodule
`default_nettype wire

// File: design/fcl_cmd_exec.sv
// Command executor: validates a launched command and times it on the flash timebase.
`timescale 1ns/1ps
`default_nettype none
module fcl_cmd_exec
   import fcl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   fcl_exec_if.exec bus
);
   fcl_exec_state_type state_q;
   logic [DIV_W-1:0] pre_q;
   logic [WORD_W-1:0] left_q;
   logic [WORD_W-1:0] used_q;
   logic [7:0] code_q;
   logic [GADDR_W-1:0] addr_q;
   logic is_pe;
   logic legal;
   logic in_prot;
   logic [GADDR_W-1:0] prot_end;
   logic tick;

   always_comb begin
      is_pe = (bus.cmd_code == CMD_PROGRAM) || (bus.cmd_code == CMD_ERASE_ALL);
      // Erase-verify-all is legal in every mode; full erase only in special mode.
      legal = (bus.cmd_code == CMD_ERASE_VERIFY_ALL)
         || (bus.cmd_code == CMD_PROGRAM)
         || (bus.cmd_code == CMD_ERASE_ALL && bus.special_mode);
      prot_end = PROT_BASE + (GADDR_W'({1'b0, bus.prot[PROT_SIZE_W-1:0]} + 5'h01)
         << PROT_GRANULE_SHIFT);
      in_prot = bus.prot[PROT_EN_BIT] && bus.cmd_code == CMD_PROGRAM
         && bus.cmd_addr >= PROT_BASE && bus.cmd_addr < prot_end;
      tick = (pre_q == bus.divider_value_field);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= FCL_IDLE;
         left_q <= '0;
         used_q <= '0;
         code_q <= '0;
         addr_q <= '0;
      end else begin
         case (state_q)
            FCL_IDLE: begin
               if (bus.launch && legal && !(is_pe && !bus.div_loaded) && !in_prot) begin
                  code_q <= bus.cmd_code;
                  addr_q <= bus.cmd_addr;
                  used_q <= '0;
                  left_q <= (bus.cmd_code == CMD_PROGRAM) ? PROGRAM_TICKS
                     : (bus.cmd_code == CMD_ERASE_ALL) ? ERASE_TICKS : VERIFY_TICKS;
                  state_q <= FCL_RUN;
               end
            end
            FCL_RUN: begin
               if (tick) begin
                  used_q <= used_q + 16'h0001;
                  left_q <= left_q - 16'h0001;
                  if (left_q == 16'h0001) begin
                     state_q <= FCL_DONE;
                  end
               end
            end
            FCL_DONE: state_q <= FCL_IDLE;
            default: state_q <= FCL_IDLE;
         endcase
      end
   end

   // The prescaler runs only while a command is timed, so each run starts aligned.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= '0;
      end else if (state_q != FCL_RUN || tick) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 7'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus.done <= 1'b0;
         bus.acc_err <= 1'b0;
         bus.prot_viol <= 1'b0;
         bus.result_we <= 1'b0;
         bus.result <= '0;
      end else begin
         bus.done <= 1'b0;
         bus.acc_err <= 1'b0;
         bus.prot_viol <= 1'b0;
         bus.result_we <= 1'b0;
         if (state_q == FCL_IDLE && bus.launch) begin
            if (!legal || (is_pe && !bus.div_loaded)) begin
               bus.acc_err <= 1'b1;
               bus.done <= 1'b1;
            end else if (in_prot) begin
               bus.prot_viol <= 1'b1;
               bus.done <= 1'b1;
            end
         end else if (state_q == FCL_DONE) begin
            bus.done <= 1'b1;
            bus.result_we <= 1'b1;
            bus.result <= used_q ^ {code_q, 8'h00} ^ {8'h00, addr_q[7:0]} ^ used_q ^ used_q;
         end
      end
   end
endmodule
`default_nettype wire

// File: design/fcl_top.sv
// Flash command launch control: APB registers, launch flag, interrupts.
`timescale 1ns/1ps
`default_nettype none
module fcl_top
   import fcl_pkg::*;
#(
   // Version number; the value is arbitrary.
   parameter logic [VER_W-1:0] VERSION_NUMBER = 4'h5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic special_mode_select,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.
   fcl_exec_if xif ();
   logic mode_meta_q;
   logic mode_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] rd_mux;
   logic mapped;
   logic access;
   logic wr_acc;
   logic rd_acc;
   logic [DIV_W-1:0] divider_value_field_q;
   logic div_loaded_q;
   logic [IDX_W-1:0] idx_q;
   logic command_complete_flag_q;
   logic access_error_flag_q;
   logic pviol_q;
   logic launch_q;
   logic [7:0] prot_q;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic irq_q;
   logic [WORD_W-1:0] slot_rd;
   logic [WORD_W-1:0] slot0;
   logic [WORD_W-1:0] slot1;
   logic ccob_wr;
   logic launch_req;
   logic [WORD_W-1:0] version_word;

   ////////////////////////////////////////////////////////////////////////////
   // Mode pin crosses in through two flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_meta_q <= 1'b0;
         mode_q <= 1'b0;
      end else begin
         mode_meta_q <= special_mode_select;
         mode_q <= mode_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state so that read data comes from a flop.
   always_comb begin
      mapped = (paddr == OFS_DIV) || (paddr == OFS_IDX) || (paddr == OFS_STAT)
         || (paddr == OFS_CCOB) || (paddr == OFS_VER) || (paddr == OFS_IRQ_STAT)
         || (paddr == OFS_IRQ_MASK) || (paddr == OFS_PROT);
      access = psel && penable && pready_q;
      wr_acc = access && pwrite && mapped;
      rd_acc = access && !pwrite && mapped;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel && penable && !pready_q;
         pslverr_q <= psel && penable && !pready_q && !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
      end else if (psel && penable && !pready_q && !pwrite) begin
         prdata_q <= rd_mux;
      end
   end

   always_comb begin
      version_word = {12'h000, VERSION_NUMBER};
      rd_mux = '0;
      case (paddr)
         OFS_DIV: rd_mux = {24'h00_0000, div_loaded_q, divider_value_field_q};
         OFS_IDX: rd_mux = {29'h0000_0000, idx_q};
         OFS_STAT: begin
            rd_mux[STAT_COMMAND_COMPLETE_FLAG_BIT] = command_complete_flag_q;
            rd_mux[STAT_ACCESS_ERROR_FLAG_BIT] = access_error_flag_q;
            rd_mux[STAT_PVIOL_BIT] = pviol_q;
            rd_mux[STAT_MODE_BIT] = mode_q;
         end
         OFS_CCOB: rd_mux = {16'h0000, slot_rd};
         OFS_VER: rd_mux = {16'h0000, version_word};
         OFS_IRQ_STAT: rd_mux = {30'h0000_0000, irq_stat_q};
         OFS_IRQ_MASK: rd_mux = {30'h0000_0000, irq_mask_q};
         OFS_PROT: rd_mux = {24'h00_0000, prot_q};
         default: rd_mux = '0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timebase divider. In normal mode it is frozen while a command runs;
   // special mode lets test software retune it at any time.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         divider_value_field_q <= DIV_RST;
         div_loaded_q <= 1'b0;
      end else if (wr_acc && paddr == OFS_DIV && (command_complete_flag_q || mode_q)) begin
         divider_value_field_q <= pwdata[DIV_W-1:0];
         div_loaded_q <= 1'b1;
      end
   end

   // Data flash protection: written only while no command runs; then special mode writes freely,
   // normal mode only while protection is still off, so it cannot be loosened in the field.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prot_q <= PROT_RST;
      end else if (wr_acc && paddr == OFS_PROT && command_complete_flag_q && (mode_q || !prot_q[PROT_EN_BIT])) begin
         prot_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_q <= IDX_RST;
      end else if (wr_acc && paddr == OFS_IDX) begin
         idx_q <= pwdata[IDX_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command launch and status flags.
   always_comb begin
      ccob_wr = wr_acc && paddr == OFS_CCOB && command_complete_flag_q;
      // A launch is refused while an error flag is still standing.
      launch_req = wr_acc && paddr == OFS_STAT && pwdata[STAT_COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag_q
         && !access_error_flag_q && !pviol_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         command_complete_flag_q <= 1'b1;
         launch_q <= 1'b0;
      end else begin
         launch_q <= launch_req;
         if (xif.done) begin
            command_complete_flag_q <= 1'b1;
         end else if (launch_req) begin
            command_complete_flag_q <= 1'b0;
         end
      end
   end

   // Hardware sets win over a software write-one-to-clear in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         access_error_flag_q <= 1'b0;
         pviol_q <= 1'b0;
      end else begin
         if (xif.acc_err) begin
            access_error_flag_q <= 1'b1;
         end else if (wr_acc && paddr == OFS_STAT && pwdata[STAT_ACCESS_ERROR_FLAG_BIT]) begin
            access_error_flag_q <= 1'b0;
         end
         if (xif.prot_viol) begin
            pviol_q <= 1'b1;
         end else if (wr_acc && paddr == OFS_STAT && pwdata[STAT_PVIOL_BIT]) begin
            pviol_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: only bits that the read actually returned are cleared, so an
   // event landing between capture and clear stays pending.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= '0;
      end else begin
         for (int b = 0; b < IRQ_W; b++) begin
            if ((b == IRQ_DONE_BIT && xif.done) || (b == IRQ_ACCESS_ERROR_FLAG_BIT && xif.acc_err)) begin
               irq_stat_q[b] <= 1'b1;
            end else if (rd_acc && paddr == OFS_IRQ_STAT && prdata_q[b]) begin
               irq_stat_q[b] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_q <= IRQ_MASK_RST;
      end else if (wr_acc && paddr == OFS_IRQ_MASK) begin
         irq_mask_q <= pwdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command object array and executor.
   fcl_cmd_array #(
      .SLOTS(SLOT_N)
   ) u_array (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(ccob_wr),
      .wr_idx(idx_q),
      .wr_data(pwdata[WORD_W-1:0]),
      .rd_idx(idx_q),
      .rd_data(slot_rd),
      .res_we(xif.result_we),
      .res_data(xif.result),
      .slot0(slot0),
      .slot1(slot1)
   );

   assign xif.launch = launch_q;
   assign xif.cmd_code = slot0[CMD_MSB:CMD_LSB];
   assign xif.cmd_addr = {slot0[ADDR_HI_W-1:0], slot1};
   assign xif.div_loaded = div_loaded_q;
   assign xif.special_mode = mode_q;
   assign xif.prot = prot_q;
   assign xif.divider_value_field = divider_value_field_q;

   fcl_cmd_exec u_exec (
      .pclk(pclk),
      .presetn(presetn),
      .bus(xif.exec)
   );

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;
endmodule
`default_nettype wire

// File: sim/fcl_top_monitor.sv
// Concurrent checks on the register bus face of the flash command launch control block.
`timescale 1ns/1ps
`default_nettype none
module fcl_top_monitor
   import fcl_pkg::*;
#(
   parameter logic [VER_W-1:0] VERSION_NUMBER = 4'h5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic special_mode_select,
   input wire logic irq
);
   logic [IDX_W-1:0] idx_q;
   logic div_seen_q;
   logic rd_ok;
   logic mapped;
   assign rd_ok = pready && !pwrite;
   assign mapped = paddr inside {OFS_DIV, OFS_IDX, OFS_STAT, OFS_CCOB, OFS_VER, OFS_IRQ_STAT,
                                 OFS_IRQ_MASK, OFS_PROT};

   ////////////////////////////////////////////////////////////////////////////
   // Shadow copies of what software wrote, so reads can be judged without peeking inside.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_q <= IDX_RST;
      end else if (pready && pwrite && paddr == OFS_IDX) begin
         idx_q <= pwdata[IDX_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_seen_q <= 1'b0;
      end else if (pready && pwrite && paddr == OFS_DIV) begin
         div_seen_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_apb_setup;
      psel && !penable;
   endsequence
   // The pin passes a two-flop synchroniser, so it must settle before its read is judged.
   sequence s_mode_steady;
      $stable(special_mode_select) [*6];
   endsequence

   a_ready_one_wait: assert property (s_apb_setup |=> !pready ##1 pready)
      else $error("ready did not follow exactly one wait state");
   a_ready_single_pulse: assert property (pready |=> !pready)
      else $error("ready stood for more than one cycle");
   a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && penable))
      else $error("ready outside an access phase");
   a_err_unmapped: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_mapped_no_err: assert property (pready && mapped |-> !pslverr)
      else $error("error on a mapped register");
   a_version_word: assert property (
      rd_ok && paddr == OFS_VER |-> prdata == {28'h0, VERSION_NUMBER})
      else $error("version word wrong");
   a_mode_visible: assert property (
      s_mode_steady ##0 (rd_ok && paddr == OFS_STAT) |-> prdata[STAT_MODE_BIT] == special_mode_select)
      else $error("status mode bit does not follow the mode pin");
   a_div_loaded: assert property (
      rd_ok && paddr == OFS_DIV |-> prdata[DIV_LOADED_BIT] == div_seen_q)
      else $error("divider loaded flag wrong");
   a_slot_reserved: assert property (
      rd_ok && paddr == OFS_CCOB && idx_q >= 3'h6 |-> prdata == 32'h0)
      else $error("unimplemented slot read not zero");
   a_upper_zero: assert property (rd_ok |-> prdata[31:16] == 16'h0)
      else $error("upper read data bits not zero");
   // The line lags its status by one flop, so the cause sits two edges back.
   a_irq_fall_cause: assert property ($fell(irq) |->
      $past(pready && ((paddr == OFS_IRQ_STAT && !pwrite) || (paddr == OFS_IRQ_MASK && pwrite)), 2))
      else $error("interrupt dropped without a status read or mask write");
endmodule

bind fcl_top fcl_top_monitor #(.VERSION_NUMBER(VERSION_NUMBER)) mon_u (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .special_mode_select(special_mode_select), .irq(irq));
`default_nettype wire

// File: sim/test_flash_command_launch_control.sv
// Self-checking bench for the flash command launch control block.
`timescale 1ns/1ps
`default_nettype none
module test_flash_command_launch_control;
   import fcl_pkg::*;
   // Version number handed to the design; the value is arbitrary.
   localparam logic [VER_W-1:0] VER = 4'h9;
   logic pclk, presetn, psel, penable, pwrite, special_mode_select;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, irq, err;
   int failures, total_checks;

   fcl_top #(.VERSION_NUMBER(VER)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .special_mode_select(special_mode_select), .irq(irq));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // One APB transfer; ready, read data and response are all taken at one rising edge.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ok;
      ok = 1'b0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20 && !ok; n++) begin
         @(posedge pclk);
         ok = (pready === 1'b1);
      end
      if (!ok) begin
         failures++;
         final_report();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask

   task automatic launch(input logic [15:0] w0, input logic [15:0] w1);
      wr(OFS_IDX, 32'h0000_0000);
      wr(OFS_CCOB, {16'h0000, w0});
      wr(OFS_IDX, 32'h0000_0001);
      wr(OFS_CCOB, {16'h0000, w1});
      wr(OFS_STAT, 32'h0000_0080);
   endtask

   task automatic wait_done();
      int n;
      for (n = 0; n < 300; n++) begin
         xfer(1'b0, OFS_STAT, 32'h0000_0000);
         if (rd[STAT_COMMAND_COMPLETE_FLAG_BIT] === 1'b1) begin
            return;
         end
      end
      failures++;
      final_report();
   endtask

   task automatic irq_is(input logic exp);
      repeat (2) @(negedge pclk);
      check({31'h0, irq}, {31'h0, exp});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd_chk(OFS_DIV, 32'h0000_0000);
      rd_chk(OFS_STAT, 32'h0000_0080);
      rd_chk(OFS_VER, {28'h0, VER});
      xfer(1'b0, 8'h04, 32'h0000_0000);
      check({31'h0, err}, 32'h0000_0001);
      irq_is(1'b0);
   endtask

   task automatic t_no_div();
      launch({CMD_PROGRAM, 8'h00}, 16'h0010);
      wait_done();
      check(rd, 32'h0000_00A0);
      xfer(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
      check(rd & 32'h0000_0002, 32'h0000_0002);
      wr(OFS_STAT, 32'h0000_0020);
      rd_chk(OFS_STAT, 32'h0000_0080);
   endtask

   task automatic t_verify();
      // A divider of one keeps runs short; real software sizes it for its bus clock.
      wr(OFS_DIV, 32'h0000_0001);
      rd_chk(OFS_DIV, 32'h0000_0081);
      wr(OFS_IRQ_MASK, 32'h0000_0001);
      launch({CMD_ERASE_VERIFY_ALL, 8'h00}, 16'h0034);
      rd_chk(OFS_STAT, 32'h0000_0000);
      wr(OFS_CCOB, 32'h0000_FFFF);
      wr(OFS_STAT, 32'h0000_0080);
      wait_done();
      check(rd, 32'h0000_0080);
      irq_is(1'b1);
      wr(OFS_IDX, 32'h0000_0002);
      rd_chk(OFS_CCOB, {16'h0, VERIFY_TICKS ^ {CMD_ERASE_VERIFY_ALL, 8'h34}});
      wr(OFS_IDX, 32'h0000_0001);
      rd_chk(OFS_CCOB, 32'h0000_0034);
      rd_chk(OFS_IRQ_STAT, 32'h0000_0001);
      rd_chk(OFS_IRQ_STAT, 32'h0000_0000);
      irq_is(1'b0);
   endtask

   task automatic t_reserved();
      for (int i = 6; i < 8; i++) begin
         wr(OFS_IDX, i);
         wr(OFS_CCOB, 32'h0000_5A5A);
         rd_chk(OFS_CCOB, 32'h0000_0000);
      end
   endtask

   // Mask is left off here, so completions must not reach the interrupt line.
   task automatic t_modes();
      wr(OFS_IRQ_MASK, 32'h0000_0000);
      launch({CMD_ERASE_ALL, 8'h00}, 16'h0000);
      wait_done();
      check(rd, 32'h0000_00A0);
      irq_is(1'b0);
      wr(OFS_STAT, 32'h0000_0020);
      xfer(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
      special_mode_select <= 1'b1;
      repeat (4) @(posedge pclk);
      launch({CMD_ERASE_ALL, 8'h00}, 16'h0000);
      rd_chk(OFS_STAT, 32'h0000_0001);
      wait_done();
      check(rd, 32'h0000_0081);
      rd_chk(OFS_IRQ_STAT, 32'h0000_0001);
      launch({CMD_ERASE_VERIFY_ALL, 8'h00}, 16'h0000);
      wait_done();
      check(rd, 32'h0000_0081);
      // Protect the first 256 bytes of the window, then program inside and just past it.
      wr(OFS_PROT, 32'h0000_0080);
      launch({CMD_PROGRAM, 8'h00}, 16'h4410);
      wait_done();
      check(rd, 32'h0000_0091);
      wr(OFS_STAT, 32'h0000_0010);
      launch({CMD_PROGRAM, 8'h00}, 16'h4500);
      wait_done();
      check(rd, 32'h0000_0081);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      special_mode_select = 1'b0;
      failures = 0;
      total_checks = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_no_div();
      t_verify();
      t_reserved();
      t_modes();
      final_report();
   end
endmodule
`default_nettype wire
